// File: verilog/adc_scan_map.svh
// Constants of the autoscan converter control: special function
// addresses, control field positions, reset values and timing counts.
// Assumes it is included by bare name from the converter control design file.
`ifndef ADC_SCAN_MAP_SVH
`define ADC_SCAN_MAP_SVH

// ----------------------------------------------------------------
// Special function addresses
// ----------------------------------------------------------------
`define ADDR_CTRL        8'hd7
`define ADDR_SCAN        8'he7
`define ADDR_RES_LO_BASE 8'he8
`define ADDR_RES_HI      8'hf7

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define CTRL_PRE_HI      7
`define CTRL_PRE_LO      6
`define CTRL_RSVD        5
`define CTRL_DONE        4
`define CTRL_SST         3
`define CTRL_MODE        2
`define CTRL_RISE        1
`define CTRL_FALL        0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTRL_RESET       8'h00
`define SCAN_RESET       8'h00

// ----------------------------------------------------------------
// Timing: core clocks per machine cycle
// ----------------------------------------------------------------
`define MC_CLKS          10'h00c

`endif

// File: verilog/adc_scan_pkg.sv
// Types shared by the autoscan converter control.
// Assumes nothing of its surroundings.
package adc_scan_pkg;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_SAMPLE  = 5'b00010,
    ST_CONVERT = 5'b00100,
    ST_STORE   = 5'b01000,
    ST_INIT    = 5'b10000
  } conv_state_t;

endpackage

// File: verilog/sync_edge.sv
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes asyncIn comes from outside the core_clk domain.
`timescale 1ns/1ns
module sync_edge (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic asyncIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic rise_q;
  logic fall_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (s2_q == s3_q && s3_q != level_q) begin
        level_q <= s3_q;
        rise_q  <= s3_q;
        fall_q  <= ~s3_q;
      end
    end
  end

  assign level = level_q;
  assign rise  = rise_q;
  assign fall  = fall_q;

endmodule // sync_edge

// File: verilog/adc_autoscan_control.sv
// Control logic of an eight-channel, ten-bit successive approximation
// converter with autonomous autoscan, reached through special function
// registers. Assumes a comparator that reports analog input at or above
// the DAC code, and an interrupt controller that applies its own enable.
//
// Function
// - Ten-bit successive approximation results, one of eight inputs per conversion.
// - Eight ten-bit result buffers; each result goes to its channel's buffer.
// - Control register at address D7H, reset to all zeros.
// - Control bits 7:6 pick prescaler divisor 2, 4, 6 or 8.
// - Done flag bit 4 set after every loop; raises the interrupt request.
// - Done flag cleared only by writing zero; writing one never sets it.
// - Setting start bit 3 by software or enabled pin edge starts scanning.
// - Continuous mode keeps start bit at one and loops while any channel is selected; an empty select clears it at loop end.
// - One-time mode clears start bit after the last selected channel.
// - While start bit is one, further start requests are ignored.
// - Software clearing the start bit aborts the conversion in progress.
// - Control bit 2 picks continuous repeating scan or a single pass.
// - Bit 1 lets a rising pin edge start conversion and capture.
// - Bit 0 lets a falling pin edge start conversion and capture.
// - Loop covers any set of one to eight inputs without processor help.
// - Scan-select bits include channels; every scan starts at lowest selected.
// - With no channel selected, no conversion starts.
// - Conversion takes 6m+1 machine cycles; conversions spaced 7m apart.
// - Low-byte read latches that channel's upper two bits into high register.
`timescale 1ns/1ns
`include "adc_scan_map.svh"
module adc_autoscan_control
  import adc_scan_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic [7:0] sfrWrData,
  input  wire logic       sfrRdEn,
  output logic      [7:0] sfrRdData,
  input  wire logic       ext_start_pin,
  input  wire logic       compOut,
  output logic      [2:0] chanSel,
  output logic      [9:0] dacCode,
  output logic            sampleEn,
  output logic            captureStrobe,
  output logic            scanDoneIrq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]  prescSel_q;
  logic        scan_done_flag_q;
  logic        start_status_bit_q;
  logic        scan_mode_bit_q;
  logic        ext_rise_enable_q;
  logic        ext_fall_enable_q;
  logic [7:0]  scan_select_reg_q;
  conv_state_t state_q;
  logic [9:0]  tmr_q;
  logic [7:0]  remain_q;
  logic [2:0]  chan_q;
  logic [9:0]  trial_q;
  logic [9:0]  mask_q;
  logic [9:0]  resBuf [0:7];
  logic [1:0]  result_high_bits_q;
  logic [7:0]  rdData_q;
  logic        capture_q;
  logic        extLevel;
  logic        extRise;
  logic        extFall;
  logic        compLevel;
  logic        wrCtrl;
  logic        wrScan;
  logic        rdResLo;
  logic        extTrig;
  logic        startReq;
  logic        swAbort;
  logic        tmrDone;
  logic [7:0]  remainNext;
  logic        loopEnd;
  logic [9:0]  bitClks;
  logic [9:0]  initClks;
  logic [9:0]  keptCode;

  // Lowest selected channel in a mask
  function automatic logic [2:0] lowestSel(input logic [7:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  sync_edge extSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  (ext_start_pin),
    .level    (extLevel),
    .rise     (extRise),
    .fall     (extFall)
  );

  sync_edge compSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  (compOut),
    .level    (compLevel),
    .rise     (),
    .fall     ()
  );

  // ----------------------------------------------------------------
  // Decode and start control
  // ----------------------------------------------------------------
  assign wrCtrl  = sfrWrEn && (sfrAddr == `ADDR_CTRL);
  assign wrScan  = sfrWrEn && (sfrAddr == `ADDR_SCAN);
  assign rdResLo = sfrRdEn && ((sfrAddr & 8'hf8) == `ADDR_RES_LO_BASE);

  assign extTrig = (extRise && ext_rise_enable_q)
                || (extFall && ext_fall_enable_q);

  // Start only when idle and at least one channel is selected
  assign startReq = !start_status_bit_q && (scan_select_reg_q != 8'h00)
                 && ((wrCtrl && sfrWrData[`CTRL_SST]) || extTrig);
  assign swAbort  = start_status_bit_q && wrCtrl && !sfrWrData[`CTRL_SST];

  // ----------------------------------------------------------------
  // Timing: divisor m = 2*(sel+1); bit period is m/2 machine cycles
  // ----------------------------------------------------------------
  assign bitClks  = 10'((10'({8'h00, prescSel_q}) + 10'h001) * `MC_CLKS);
  assign initClks = 10'((10'({7'h00, prescSel_q, 1'b0}) + 10'h001) * `MC_CLKS);
  assign tmrDone  = (tmr_q == 10'h000);

  assign remainNext = remain_q & ~(8'h01 << chan_q);
  assign loopEnd    = (state_q == ST_STORE) && tmrDone && (remainNext == 8'h00) && !swAbort;
  assign keptCode   = compLevel ? trial_q : (trial_q & ~mask_q);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prescSel_q        <= 2'(`CTRL_RESET >> `CTRL_PRE_LO);
      scan_mode_bit_q   <= 1'b0;
      ext_rise_enable_q <= 1'b0;
      ext_fall_enable_q <= 1'b0;
    end else if (wrCtrl) begin
      prescSel_q        <= sfrWrData[`CTRL_PRE_HI:`CTRL_PRE_LO];
      scan_mode_bit_q   <= sfrWrData[`CTRL_MODE];
      ext_rise_enable_q <= sfrWrData[`CTRL_RISE];
      ext_fall_enable_q <= sfrWrData[`CTRL_FALL];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scan_done_flag_q <= 1'b0;
    end else if (loopEnd) begin
      scan_done_flag_q <= 1'b1;
    end else if (wrCtrl && !sfrWrData[`CTRL_DONE]) begin
      scan_done_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      start_status_bit_q <= 1'b0;
    end else if (startReq) begin
      start_status_bit_q <= 1'b1;
    end else if (swAbort) begin
      start_status_bit_q <= 1'b0;
    end else if (loopEnd && (!scan_mode_bit_q || scan_select_reg_q == 8'h00)) begin
      start_status_bit_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scan_select_reg_q <= `SCAN_RESET;
    end else if (wrScan) begin
      scan_select_reg_q <= sfrWrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      capture_q <= 1'b0;
    end else begin
      capture_q <= extTrig;
    end
  end

  // ----------------------------------------------------------------
  // Autoscan sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q  <= ST_IDLE;
      tmr_q    <= 10'h000;
      remain_q <= 8'h00;
      chan_q   <= 3'h0;
      trial_q  <= 10'h000;
      mask_q   <= 10'h000;
    end else if (swAbort) begin
      state_q <= ST_IDLE;
      tmr_q   <= 10'h000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (startReq) begin
            remain_q <= scan_select_reg_q;
            chan_q   <= lowestSel(scan_select_reg_q);
            tmr_q    <= 10'((bitClks << 1) - 10'h001);
            state_q  <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (tmrDone) begin
            trial_q <= 10'h200;
            mask_q  <= 10'h200;
            tmr_q   <= 10'(bitClks - 10'h001);
            state_q <= ST_CONVERT;
          end else begin
            tmr_q <= 10'(tmr_q - 10'h001);
          end
        end
        ST_CONVERT: begin
          if (tmrDone) begin
            // Keep the trial bit when the input is at or above the code
            trial_q <= keptCode | (mask_q >> 1);
            mask_q  <= mask_q >> 1;
            if (mask_q[0]) begin
              tmr_q   <= 10'(`MC_CLKS - 10'h001);
              state_q <= ST_STORE;
            end else begin
              tmr_q <= 10'(bitClks - 10'h001);
            end
          end else begin
            tmr_q <= 10'(tmr_q - 10'h001);
          end
        end
        ST_STORE: begin
          if (tmrDone) begin
            tmr_q <= 10'(initClks - 10'h001);
            if (remainNext != 8'h00) begin
              remain_q <= remainNext;
              chan_q   <= lowestSel(remainNext);
              state_q  <= ST_INIT;
            end else if (scan_mode_bit_q && scan_select_reg_q != 8'h00) begin
              remain_q <= scan_select_reg_q;
              chan_q   <= lowestSel(scan_select_reg_q);
              state_q  <= ST_INIT;
            end else begin
              remain_q <= 8'h00;
              state_q  <= ST_IDLE;
            end
          end else begin
            tmr_q <= 10'(tmr_q - 10'h001);
          end
        end
        ST_INIT: begin
          if (tmrDone) begin
            tmr_q   <= 10'((bitClks << 1) - 10'h001);
            state_q <= ST_SAMPLE;
          end else begin
            tmr_q <= 10'(tmr_q - 10'h001);
          end
        end
        default: begin
          state_q <= ST_IDLE;
          tmr_q   <= 10'h000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result buffers, not affected by reset
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (state_q == ST_STORE && tmrDone && !swAbort) begin
      resBuf[chan_q] <= trial_q;
    end
  end

  // ----------------------------------------------------------------
  // Register reads, answered one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rdResLo) begin
      result_high_bits_q <= resBuf[sfrAddr[2:0]][9:8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdData_q <= 8'h00;
    end else if (!sfrRdEn) begin
      rdData_q <= 8'h00;
    end else if (sfrAddr == `ADDR_CTRL) begin
      // Reserved bit reads as zero
      rdData_q <= {prescSel_q, 1'b0, scan_done_flag_q, start_status_bit_q,
                   scan_mode_bit_q, ext_rise_enable_q, ext_fall_enable_q};
    end else if (sfrAddr == `ADDR_SCAN) begin
      rdData_q <= scan_select_reg_q;
    end else if (rdResLo) begin
      rdData_q <= resBuf[sfrAddr[2:0]][7:0];
    end else if (sfrAddr == `ADDR_RES_HI) begin
      rdData_q <= {6'h00, result_high_bits_q};
    end else begin
      rdData_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfrRdData     = rdData_q;
  assign chanSel       = chan_q;
  assign dacCode       = trial_q;
  assign sampleEn      = (state_q == ST_SAMPLE);
  assign captureStrobe = capture_q;
  assign scanDoneIrq   = scan_done_flag_q;

endmodule // adc_autoscan_control

// File: tb/adc_scan_asserts.sv
// Port-level checker for the autoscan converter control.
// Assumes the bind at the foot attaches it to adc_autoscan_control.
`timescale 1ns/1ns
module adc_scan_asserts (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic       sfrRdEn,
  input wire logic [7:0] sfrRdData,
  input wire logic       ext_start_pin,
  input wire logic       compOut,
  input wire logic [2:0] chanSel,
  input wire logic [9:0] dacCode,
  input wire logic       sampleEn,
  input wire logic       captureStrobe,
  input wire logic       scanDoneIrq
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic [7:0] sampLen_q;
  logic       doneClr;
  assign doneClr = sfrWrEn && sfrAddr == 8'hd7 && !sfrWrData[4];
  always_ff @(posedge core_clk) begin
    if (!rst_n || !sampleEn) begin
      sampLen_q <= 8'h00;
    end else begin
      sampLen_q <= sampLen_q + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Sampling ended by the converter, not cut short by a control write
  sequence convStart_s;
    $fell(sampleEn) && !$past(sfrWrEn);
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  rst_quiet_a: assert property ($rose(rst_n) |-> sfrRdData == 8'h00 && !sampleEn && !scanDoneIrq)
    else $error("outputs not quiet after reset");
  rd_idle_a: assert property (!sfrRdEn |=> sfrRdData == 8'h00)
    else $error("read data without a read");
  cap_pulse_a: assert property (captureStrobe |=> !captureStrobe)
    else $error("capture strobe longer than one cycle");
  done_hold_a: assert property (scanDoneIrq && !doneClr |=> scanDoneIrq)
    else $error("done flag dropped without a clearing write");
  samp_len_a: assert property (convStart_s |-> sampLen_q inside {8'h18, 8'h30, 8'h48, 8'h60})
    else $error("sample period length wrong");
  dac_msb_a: assert property (convStart_s |-> ##[0:1] dacCode == 10'h200)
    else $error("first trial code is not the msb");
  conv_gap_a: assert property (convStart_s |-> !sampleEn [*8])
    else $error("sampling resumed during conversion");
  chan_hold_a: assert property (sampleEn && $past(sampleEn) |-> $stable(chanSel))
    else $error("channel changed while sampling");
endmodule // adc_scan_asserts

bind adc_autoscan_control adc_scan_asserts u_asserts (.core_clk, .rst_n, .sfrAddr, .sfrWrEn, .sfrWrData,
  .sfrRdEn, .sfrRdData, .ext_start_pin, .compOut, .chanSel, .dacCode, .sampleEn, .captureStrobe,
  .scanDoneIrq);

// File: tb/analog_front_model.sv
// Ideal analog inputs and comparator facing the converter control.
// Assumes ten-bit levels packed eight to a bus, channel 0 lowest.
`timescale 1ns/1ns
module analog_front_model (
  input  wire logic [79:0] levelBus,
  input  wire logic [2:0]  chanSel,
  input  wire logic [9:0]  dacCode,
  output logic             compOut
);
  assign compOut = (levelBus[chanSel*10 +: 10] >= dacCode);
endmodule // analog_front_model

// File: tb/testbench.sv
// Self-checking bench for adc_autoscan_control.
// Assumes the design, its header, the front model and the checker are compiled.
`timescale 1ns/1ns
module testbench;
  logic        core_clk, rst_n, sfrWrEn, sfrRdEn, ext_start_pin;
  logic [7:0]  sfrAddr, sfrWrData, sfrRdData, sel;
  logic [2:0]  chanSel;
  logic [9:0]  dacCode;
  logic        compOut, sampleEn, captureStrobe, scanDoneIrq;
  logic [79:0] levelBus;
  logic [15:0] seed;
  int          bad_count, n_tests, cycles, capCnt, t, p, ch, lo, c0;
  int          lvl[8];

  adc_autoscan_control dut (.core_clk, .rst_n, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn, .sfrRdData,
    .ext_start_pin, .compOut, .chanSel, .dacCode, .sampleEn, .captureStrobe, .scanDoneIrq);
  analog_front_model afe (.levelBus, .chanSel, .dacCode, .compOut);

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (captureStrobe === 1'b1) capCnt <= capCnt + 1;
    if (cycles == 40000) begin
      bad_count++;
      final_report();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (exp !== seen) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step;
    @(posedge core_clk);
    #1;
    t++;
  endtask
  task automatic waitSig(input bit irq, input int lim);
    int k;
    k = 0;
    while (k < lim && (irq ? scanDoneIrq : sampleEn) !== 1'b1) begin
      step();
      k++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge core_clk);
    sfrWrEn <= 1'b0;
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge core_clk);
    sfrRdEn <= 1'b0;
    #1;
    chk(what, {24'h0, exp}, {24'h0, sfrRdData});
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    sfrWrEn = 1'b0;
    sfrRdEn = 1'b0;
    ext_start_pin = 1'b0;
    levelBus = '0;
    seed = 16'h004f;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    // ------------------------------------------------------------
    // Reset values and refused start
    // ------------------------------------------------------------
    rdChk("ctrl reset", 8'hd7, 8'h00);
    rdChk("select reset", 8'he7, 8'h00);
    rdChk("unmapped", 8'h10, 8'h00);
    wr(8'hd7, 8'hcf);
    repeat (30) step();
    chk("no start", 32'h0, {31'h0, sampleEn});
    rdChk("ctrl fields", 8'hd7, 8'hc7);
    wr(8'hd7, 8'h00);
    $display("test reset done");
    // ------------------------------------------------------------
    // One-time scans at every prescaler setting
    // ------------------------------------------------------------
    for (p = 0; p < 4; p++) begin
      for (ch = 0; ch < 8; ch++) begin
        seed = lfsr(seed);
        lvl[ch] = int'(seed[9:0]);
        levelBus[ch*10 +: 10] <= seed[9:0];
      end
      seed = lfsr(seed);
      sel = seed[7:0] | 8'h06;
      lo = sel[0] ? 0 : 1;
      wr(8'he7, sel);
      wr(8'hd7, {p[1:0], 6'b001000});
      waitSig(0, 300);
      chk("first channel", lo, {29'h0, chanSel});
      // Measure from the end of one sample period to the end of the next
      while (sampleEn === 1'b1) step();
      t = 0;
      while (t < 2000 && sampleEn !== 1'b1) step();
      while (t < 2000 && sampleEn === 1'b1) step();
      chk("scan spacing", 84 * 2 * (p + 1), t);
      waitSig(1, 20000);
      rdChk("done one-time", 8'hd7, {p[1:0], 6'b010000});
      for (ch = 0; ch < 8; ch++) begin
        if (sel[ch]) begin
          rdChk("result low", 8'he8 + ch[7:0], lvl[ch][7:0]);
          rdChk("result high", 8'hf7, {6'h00, lvl[ch][9:8]});
        end
      end
      wr(8'hd7, {p[1:0], 6'b010000});
      rdChk("done kept", 8'hd7, {p[1:0], 6'b010000});
      wr(8'hd7, 8'h00);
      rdChk("done cleared", 8'hd7, 8'h00);
      chk("irq low", 32'h0, {31'h0, scanDoneIrq});
    end
    wr(8'hd7, 8'h10);
    rdChk("done not set", 8'hd7, 8'h00);
    $display("test one-time done");
    // ------------------------------------------------------------
    // Continuous scan, then abort
    // ------------------------------------------------------------
    wr(8'he7, 8'h81);
    wr(8'hd7, 8'h0c);
    waitSig(1, 3000);
    rdChk("continuous", 8'hd7, 8'h1c);
    waitSig(0, 400);
    wr(8'hd7, 8'h14);
    lo = 0;
    repeat (400) begin
      step();
      if (sampleEn !== 1'b0) lo = 1;
    end
    chk("aborted", 32'h0, lo);
    rdChk("abort ctrl", 8'hd7, 8'h14);
    wr(8'hd7, 8'h00);
    $display("test continuous done");
    // ------------------------------------------------------------
    // External start edges under each enable setting
    // ------------------------------------------------------------
    wr(8'he7, 8'h10);
    for (p = 0; p < 4; p++) begin
      wr(8'hd7, {6'h00, p[1:0]});
      c0 = capCnt;
      @(posedge core_clk);
      ext_start_pin <= 1'b1;
      repeat (10) @(posedge core_clk);
      ext_start_pin <= 1'b0;
      repeat (10) @(posedge core_clk);
      chk("captures", (p + 1) / 2, capCnt - c0);
      rdChk("ext start", 8'hd7, {4'h0, p != 0, 1'b0, p[1:0]});
      wr(8'hd7, 8'h00);
      repeat (5) @(posedge core_clk);
    end
    $display("test ext pin done");
    final_report();
  end
endmodule // testbench
